// [ddcf_defs.vh]
`ifndef DDCF_DEFS_VH
`define DDCF_DEFS_VH

// ----------------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------------
`define DDCF_ADDR_W        8
`define DDCF_DATA_W        32

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define DDCF_OFS_CTRL      8'h00
`define DDCF_OFS_STATUS    8'h04
`define DDCF_OFS_OFFSET    8'h08
`define DDCF_OFS_SAMPLE    8'h0C

// ----------------------------------------------------------------------------
// Control word field positions and reset value
// ----------------------------------------------------------------------------
`define DDCF_CTRL_INTERP   0
`define DDCF_CTRL_TWOS     1
`define DDCF_CTRL_SHIFT_LO 4
`define DDCF_CTRL_SHIFT_HI 7
`define DDCF_CTRL_LEN_LO   8
`define DDCF_CTRL_LEN_HI   9
`define DDCF_CTRL_RESET    10'h000

// ----------------------------------------------------------------------------
// Status word field positions
// ----------------------------------------------------------------------------
`define DDCF_STAT_SHIFT_LO 0
`define DDCF_STAT_SHIFT_HI 3
`define DDCF_STAT_AGC      4
`define DDCF_STAT_OVERRUN  5
`define DDCF_STAT_RX_BUSY  6

// ----------------------------------------------------------------------------
// Constants
// ----------------------------------------------------------------------------
`define DDCF_SHIFT_MAX     4'hF
`define DDCF_RESP_OKAY     2'h0
`define DDCF_RESP_SLVERR   2'h2

`endif

// [ddcf_offset_rx.v]
`include "ddcf_defs.vh"
`default_nettype none

module ddcf_offset_rx (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        bit_tick,
   input  wire        serial_bit,
   input  wire        frame_mark,
   input  wire [1:0]  word_len,
   output reg  [31:0] offset_word,
   output reg         offset_load,
   output wire        rx_busy
);

   reg  [31:0] sr_r;
   reg  [4:0]  cnt_r;
   reg         busy_r;
   wire [31:0] sr_nxt;
   wire [4:0]  last_idx;
   wire [4:0]  align;

   assign sr_nxt   = {sr_r[30:0], serial_bit};
   assign last_idx = {word_len, 3'h7};
   assign align    = {~word_len, 3'h0};
   assign rx_busy  = busy_r;

   // Mark seen on one tick puts the MSB on the next; a new mark restarts
   always @(posedge aclk) begin
      if (!aresetn) begin
         sr_r        <= 32'h00000000;
         cnt_r       <= 5'h00;
         busy_r      <= 1'b0;
         offset_word <= 32'h00000000;
         offset_load <= 1'b0;
      end else begin
         offset_load <= 1'b0;
         if (bit_tick) begin
            if (frame_mark) begin
               busy_r <= 1'b1; // RULE_11
               cnt_r  <= 5'h00;
               sr_r   <= 32'h00000000;
            end else if (busy_r) begin
               sr_r  <= sr_nxt; // RULE_10
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == last_idx) begin
                  // Short words sit in the top bits of the NCO word
                  offset_word <= sr_nxt << align; // RULE_13
                  offset_load <= 1'b1;
                  busy_r      <= 1'b0;
               end
            end
         end
      end
   end

endmodule

`default_nettype wire

// [ddcf_front_end.v]
// Functional notes
// (RULE_01) Every input-side action happens at a rising edge of the input sample clock.
// (RULE_02) The 14-bit sample, bit 13 the MSB, is read as offset binary or two's complement.
// (RULE_03) The active-low input enable works gated or interpolated, chosen by control bit 0.
// (RULE_04) Gated mode takes exactly one sample per input clock with the enable asserted.
// (RULE_05) The coarse gain offset is added to the programmed shift code, saturating at F.
// (RULE_06) Each coarse gain step is one shift position, 6 dB, so 000 adds none and 111 42 dB.
// (RULE_07) Everything past the CIC point is timed by rising edges of the processing clock.
// (RULE_08) Samples pass safely from the input clock side to the asynchronous processing side.
// (RULE_09) The AGC gain pick is sampled on the processing clock; high selects gain setting 1.
// (RULE_10) A serial carrier offset of 8, 16, 24 or 32 bits is shifted in on the input clock.
// (RULE_11) The source raises the frame mark one input clock before the offset word's MSB.
// (RULE_12) Interpolated mode inserts zero samples where the enable is off, one per clock.
// (RULE_13) The carrier offset loads only after the full configured word length arrives.
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`include "ddcf_defs.vh"
`default_nettype none

module ddcf_front_end (
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite slave
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Input side
   input  wire        input_sample_clock,
   input  wire [13:0] sample_in,
   input  wire        input_enable_n,
   input  wire [2:0]  coarse_gain_offset,
   input  wire        carrier_offset_serial,
   input  wire        carrier_offset_frame_mark,
   // Processing side
   input  wire        processing_clock,
   input  wire        agc_loop_gain_pick,
   // Results
   output reg  [13:0] input_sample,
   output reg         input_sample_valid,
   output reg  [3:0]  mixer_shift_code,
   output reg  [31:0] carrier_offset,
   output reg         carrier_offset_load,
   output reg  [13:0] proc_sample,
   output reg         proc_sample_valid,
   output reg         agc_gain_setting
);

   // -------------------------------------------------------------------------
   // Clock edge detection
   // -------------------------------------------------------------------------
   // Both clocks are oversampled by aclk; inputs are taken as synchronous,
   // so no synchroniser is placed ahead of the edge detectors.
   reg         isc_d_r;
   reg         pclk_d_r;
   wire        isc_rise;
   wire        pclk_rise;

   assign isc_rise  = input_sample_clock & ~isc_d_r;
   assign pclk_rise = processing_clock & ~pclk_d_r;

   always @(posedge aclk) begin
      if (!aresetn) begin
         isc_d_r  <= 1'b0;
         pclk_d_r <= 1'b0;
      end else begin
         isc_d_r  <= input_sample_clock;
         pclk_d_r <= processing_clock;
      end
   end

   // -------------------------------------------------------------------------
   // Control and status state
   // -------------------------------------------------------------------------
   reg  [9:0]  ctrl_r;
   reg         overrun_r;
   wire        mode_interp;
   wire        fmt_twos;
   wire [3:0]  shift_prog;
   wire [1:0]  word_len;
   wire        rx_busy;
   wire [31:0] rx_word;
   wire        rx_load;

   assign mode_interp = ctrl_r[`DDCF_CTRL_INTERP];
   assign fmt_twos    = ctrl_r[`DDCF_CTRL_TWOS];
   assign shift_prog  = ctrl_r[`DDCF_CTRL_SHIFT_HI:`DDCF_CTRL_SHIFT_LO];
   assign word_len    = ctrl_r[`DDCF_CTRL_LEN_HI:`DDCF_CTRL_LEN_LO];

   // -------------------------------------------------------------------------
   // Sample capture on the input clock
   // -------------------------------------------------------------------------
   wire [13:0] sample_twos;
   wire        take_real;
   wire        take_zero;
   wire [4:0]  shift_sum;
   reg  [13:0] hold_r;
   reg         hold_full_r;
   wire        cap_now;

   // Offset binary becomes two's complement by inverting the MSB
   assign sample_twos = fmt_twos ? sample_in
                                 : {~sample_in[13], sample_in[12:0]}; // RULE_02
   assign take_real   = isc_rise & ~input_enable_n;                   // RULE_04
   assign take_zero   = isc_rise & input_enable_n & mode_interp;      // RULE_12
   assign cap_now     = take_real | take_zero;                        // RULE_03

   // One shift position is a factor of two, i.e. 6 dB per gain step
   assign shift_sum   = {1'b0, shift_prog} + {2'h0, coarse_gain_offset}; // RULE_06

   always @(posedge aclk) begin
      if (!aresetn) begin
         input_sample       <= 14'h0000;
         input_sample_valid <= 1'b0;
         mixer_shift_code   <= 4'h0;
      end else begin
         input_sample_valid <= cap_now;
         if (take_real) begin
            input_sample <= sample_twos; // RULE_01
         end else if (take_zero) begin
            input_sample <= 14'h0000;
         end
         if (isc_rise) begin
            if (shift_sum > {1'b0, `DDCF_SHIFT_MAX}) begin
               mixer_shift_code <= `DDCF_SHIFT_MAX; // RULE_05
            end else begin
               mixer_shift_code <= shift_sum[3:0];
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Crossing to the processing clock
   // -------------------------------------------------------------------------
   // One-word holding stage; a second capture before the processing side
   // has taken the first overwrites it and raises the sticky overrun flag.
   reg         ovr_clear;

   always @(posedge aclk) begin
      if (!aresetn) begin
         hold_r            <= 14'h0000;
         hold_full_r       <= 1'b0;
         proc_sample       <= 14'h0000;
         proc_sample_valid <= 1'b0;
         agc_gain_setting  <= 1'b0;
         overrun_r         <= 1'b0;
      end else begin
         proc_sample_valid <= 1'b0;
         if (pclk_rise) begin
            agc_gain_setting <= agc_loop_gain_pick; // RULE_09
            if (hold_full_r) begin
               proc_sample       <= hold_r; // RULE_07
               proc_sample_valid <= 1'b1;
            end
         end
         if (cap_now) begin
            hold_r      <= take_real ? sample_twos : 14'h0000; // RULE_08
            hold_full_r <= 1'b1;
         end else if (pclk_rise) begin
            hold_full_r <= 1'b0;
         end
         // Set beats clear when both land together
         if (cap_now && hold_full_r && !pclk_rise) begin
            overrun_r <= 1'b1;
         end else if (ovr_clear) begin
            overrun_r <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Serial carrier offset
   // -------------------------------------------------------------------------
   ddcf_offset_rx u_offset_rx (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .bit_tick    (isc_rise),
      .serial_bit  (carrier_offset_serial),
      .frame_mark  (carrier_offset_frame_mark),
      .word_len    (word_len),
      .offset_word (rx_word),
      .offset_load (rx_load),
      .rx_busy     (rx_busy)
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         carrier_offset      <= 32'h00000000;
         carrier_offset_load <= 1'b0;
      end else begin
         carrier_offset_load <= rx_load;
         if (rx_load) begin
            carrier_offset <= rx_word; // RULE_10
         end
      end
   end

   // -------------------------------------------------------------------------
   // AXI4-Lite write channel
   // -------------------------------------------------------------------------
   reg         aw_full_r;
   reg  [7:0]  aw_addr_r;
   reg         w_full_r;
   reg  [31:0] w_data_r;
   reg  [3:0]  w_strb_r;
   wire        wr_go;

   assign s_axi_awready = ~aw_full_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_full_r & ~s_axi_bvalid;
   assign wr_go         = aw_full_r & w_full_r;

   always @* begin
      ovr_clear = wr_go && (aw_addr_r == `DDCF_OFS_STATUS) && w_strb_r[0]
                  && w_data_r[`DDCF_STAT_OVERRUN];
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r    <= 1'b0;
         aw_addr_r    <= 8'h00;
         w_full_r     <= 1'b0;
         w_data_r     <= 32'h00000000;
         w_strb_r     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `DDCF_RESP_OKAY;
         ctrl_r       <= `DDCF_CTRL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_full_r    <= 1'b0;
            w_full_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `DDCF_RESP_OKAY;
            case (aw_addr_r)
               `DDCF_OFS_CTRL: begin
                  if (w_strb_r[0]) begin
                     ctrl_r[7:0] <= w_data_r[7:0];
                  end
                  if (w_strb_r[1]) begin
                     ctrl_r[9:8] <= w_data_r[9:8];
                  end
               end
               `DDCF_OFS_STATUS,
               `DDCF_OFS_OFFSET,
               `DDCF_OFS_SAMPLE: begin
                  s_axi_bresp <= `DDCF_RESP_OKAY;
               end
               default: begin
                  s_axi_bresp <= `DDCF_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // AXI4-Lite read channel
   // -------------------------------------------------------------------------
   wire [31:0] status_word;

   assign s_axi_arready = ~s_axi_rvalid;
   assign status_word   = {25'h0000000, rx_busy, overrun_r, agc_gain_setting,
                           mixer_shift_code};

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `DDCF_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `DDCF_RESP_OKAY;
            case (s_axi_araddr)
               `DDCF_OFS_CTRL: begin
                  s_axi_rdata <= {22'h000000, ctrl_r};
               end
               `DDCF_OFS_STATUS: begin
                  s_axi_rdata <= status_word;
               end
               `DDCF_OFS_OFFSET: begin
                  s_axi_rdata <= carrier_offset;
               end
               `DDCF_OFS_SAMPLE: begin
                  s_axi_rdata <= {18'h00000, input_sample};
               end
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `DDCF_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// [ddcf_chk_assertions.sv]
`default_nettype none
module ddcf_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        input_sample_clock,
   input wire logic        input_enable_n,
   input wire logic [2:0]  coarse_gain_offset,
   input wire logic        processing_clock,
   input wire logic        agc_loop_gain_pick,
   input wire logic [13:0] input_sample,
   input wire logic        input_sample_valid,
   input wire logic [3:0]  mixer_shift_code,
   input wire logic        carrier_offset_load,
   input wire logic        proc_sample_valid,
   input wire logic        agc_gain_setting
);
   timeunit 1ns;
   timeprecision 1ns;
   logic ick_r;
   logic pck_r;
   wire  irise = input_sample_clock & ~ick_r;
   wire  prise = processing_clock & ~pck_r;
   // ------
   // Edge mirrors, cleared like the design's
   // ------
   always_ff @(posedge aclk) begin
      ick_r <= aresetn & input_sample_clock;
      pck_r <= aresetn & processing_clock;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_rise; input_sample_valid |-> $past(irise); endproperty
   a_rise: assert property (p_rise) else $error("sample without clock rise");
   property p_take; irise && !input_enable_n |=> input_sample_valid; endproperty
   a_take: assert property (p_take) else $error("enabled sample missed");
   property p_zero; input_sample_valid && $past(input_enable_n) |-> input_sample == 14'h0000;
   endproperty
   a_zero: assert property (p_zero) else $error("inserted sample not zero");
   property p_gain; irise && coarse_gain_offset == 3'h7 |=> mixer_shift_code >= 4'h7;
   endproperty
   a_gain: assert property (p_gain) else $error("gain steps lost");
   property p_hold; !$past(irise) |-> $stable(mixer_shift_code); endproperty
   a_hold: assert property (p_hold) else $error("shift code moved off rise");
   property p_agc; prise |=> agc_gain_setting == $past(agc_loop_gain_pick); endproperty
   a_agc: assert property (p_agc) else $error("agc pick not followed");
   property p_proc; proc_sample_valid |-> $past(prise); endproperty
   a_proc: assert property (p_proc) else $error("proc sample off proc edge");
   property p_load; carrier_offset_load |-> $past(irise, 2); endproperty
   a_load: assert property (p_load) else $error("offset load off rise");
   c_zero: cover property (input_sample_valid && input_sample == 14'h0000);
   c_sat: cover property (mixer_shift_code == 4'hF);
   c_load: cover property (carrier_offset_load);
endmodule
`default_nettype wire

// [ddcf_src.sv]
`default_nettype none
module ddcf_src (
   input  wire logic        aclk,
   output var  logic        input_sample_clock,
   output var  logic [13:0] sample_in,
   output var  logic        input_enable_n,
   output var  logic        carrier_offset_serial,
   output var  logic        carrier_offset_frame_mark
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      input_sample_clock = 1'b0;
      sample_in = 14'h0000;
      input_enable_n = 1'b1;
      carrier_offset_serial = 1'b0;
      carrier_offset_frame_mark = 1'b0;
   end
   // ------
   // One input clock: two aclk low, two high
   // ------
   task automatic tick(input logic [13:0] d, input logic en_n, input logic sb, input logic mk);
      @(posedge aclk);
      input_sample_clock <= 1'b0;
      sample_in <= d;
      input_enable_n <= en_n;
      carrier_offset_serial <= sb;
      carrier_offset_frame_mark <= mk;
      repeat (2) @(posedge aclk);
      input_sample_clock <= 1'b1;
      @(posedge aclk);
   endtask
   // Idle lines flip so a stale value cannot pass
   task automatic sample(input logic [13:0] d, input logic en_n);
      tick(en_n ? ~sample_in : d, en_n, ~carrier_offset_serial, 1'b0);
   endtask
   task automatic send_word(input logic [31:0] w, input int n);
      tick(~sample_in, 1'b1, ~carrier_offset_serial, 1'b1);
      for (int k = 0; k < n; k++) tick(~sample_in, 1'b1, w[31 - k], 1'b0);
   endtask
endmodule
`default_nettype wire

// [test_ddc_input_front_end.sv]
`default_nettype none
module test_ddc_input_front_end;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk, aresetn, agc_loop_gain_pick;
   logic        processing_clock = 1'b0, pclk_run = 1'b1;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, carrier_offset;
   logic [3:0]  s_axi_wstrb, mixer_shift_code;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, input_sample_valid, carrier_offset_load;
   logic        proc_sample_valid, agc_gain_setting, input_sample_clock, input_enable_n;
   logic        carrier_offset_serial, carrier_offset_frame_mark;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [13:0] sample_in, input_sample, proc_sample, smp, psmp;
   logic [2:0]  coarse_gain_offset;
   int          mismatches = 0, checks = 0, nsmp = 0, nld = 0, i, n;
   ddcf_front_end u_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .input_sample_clock(input_sample_clock), .sample_in(sample_in),
      .input_enable_n(input_enable_n), .coarse_gain_offset(coarse_gain_offset),
      .carrier_offset_serial(carrier_offset_serial),
      .carrier_offset_frame_mark(carrier_offset_frame_mark),
      .processing_clock(processing_clock), .agc_loop_gain_pick(agc_loop_gain_pick),
      .input_sample(input_sample), .input_sample_valid(input_sample_valid),
      .mixer_shift_code(mixer_shift_code), .carrier_offset(carrier_offset),
      .carrier_offset_load(carrier_offset_load), .proc_sample(proc_sample),
      .proc_sample_valid(proc_sample_valid), .agc_gain_setting(agc_gain_setting)
   );
   ddcf_src       u_src (
      .aclk(aclk), .input_sample_clock(input_sample_clock), .sample_in(sample_in),
      .input_enable_n(input_enable_n), .carrier_offset_serial(carrier_offset_serial),
      .carrier_offset_frame_mark(carrier_offset_frame_mark)
   );
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always begin
      repeat (3) @(posedge aclk);
      // Stoppable so two captures can meet one held word
      if (pclk_run) processing_clock <= ~processing_clock;
   end
   always @(posedge aclk) begin
      if (input_sample_valid) begin
         smp <= input_sample;
         nsmp <= nsmp + 1;
      end
      if (carrier_offset_load) nld <= nld + 1;
      if (proc_sample_valid) psmp <= proc_sample;
   end
   // ------
   // Checking and closing
   // ------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic timeout;
      mismatches++;
      report_and_stop();
   endtask
   task automatic settle;
      repeat (6) @(posedge aclk);
   endtask
   // ------
   // Bus cycles
   // ------
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      logic ta, tw, tb;
      logic [1:0] rsp;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(negedge aclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) break;
      end
      s_axi_bready <= 1'b0;
      if (k == 100) timeout();
      chk("bresp", rsp, er);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int k;
      logic ta, tr;
      logic [31:0] dat;
      logic [1:0] rsp;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(negedge aclk);
         ta = s_axi_arvalid & s_axi_arready;
         tr = s_axi_rvalid;
         dat = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) break;
      end
      s_axi_rready <= 1'b0;
      if (k == 100) timeout();
      chk("rdata", dat, ed);
      chk("rresp", rsp, er);
   endtask
   initial begin
      {aresetn, agc_loop_gain_pick, s_axi_awvalid} = 3'h0;
      {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      coarse_gain_offset = 3'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(8'h00, 32'h0, 2'h0);
      rd(8'h10, 32'h0, 2'h2);
      wr(8'h20, 32'h1, 2'h2);
      n = nsmp;
      u_src.sample(14'h2005, 1'b0);
      u_src.sample(14'h1234, 1'b1);
      settle();
      chk("gated", smp, 32'h5);
      chk("count", nsmp, n + 1);
      chk("proc", psmp, 32'h5);
      rd(8'h0C, 32'h5, 2'h0);
      wr(8'h00, 32'h3, 2'h0);
      rd(8'h00, 32'h3, 2'h0);
      n = nsmp;
      u_src.sample(14'h2ABC, 1'b1);
      settle();
      chk("interp", smp, 32'h0);
      u_src.sample(14'h2ABC, 1'b0);
      settle();
      chk("twos", smp, 32'h2ABC);
      chk("count", nsmp, n + 2);
      wr(8'h00, 32'hA3, 2'h0);
      for (i = 0; i < 8; i++) begin
         coarse_gain_offset <= i[2:0];
         u_src.sample(14'h0001, 1'b0);
         settle();
         chk("shift", mixer_shift_code, (i > 5) ? 15 : i + 10);
      end
      for (i = 0; i < 4; i++) begin
         wr(8'h00, i * 256, 2'h0);
         n = nld;
         u_src.send_word(32'hC3A596E1, 8 * (i + 1));
         settle();
         chk("offset", carrier_offset, 32'hC3A596E1 & ~(32'hFFFFFFFF >> (8 * (i + 1))));
         chk("load", nld, n + 1);
      end
      rd(8'h08, 32'hC3A596E1, 2'h0);
      for (i = 0; i < 2; i++) begin
         agc_loop_gain_pick <= (i == 0);
         repeat (8) @(posedge aclk);
         chk("agc", agc_gain_setting, (i == 0));
      end
      pclk_run = 1'b0;
      wr(8'h04, 32'h20, 2'h0);
      rd(8'h04, 32'h07, 2'h0);
      u_src.sample(14'h0000, 1'b0);
      u_src.sample(14'h0000, 1'b0);
      rd(8'h04, 32'h27, 2'h0);
      wr(8'h04, 32'h20, 2'h0);
      rd(8'h04, 32'h07, 2'h0);
      s_axi_wstrb <= 4'h1;
      wr(8'h00, 32'h0F0, 2'h0);
      s_axi_wstrb <= 4'hF;
      rd(8'h00, 32'h3F0, 2'h0);
      report_and_stop();
   end
endmodule
bind ddcf_front_end ddcf_chk u_chk (
   .aclk(aclk), .aresetn(aresetn), .input_sample_clock(input_sample_clock),
   .input_enable_n(input_enable_n), .coarse_gain_offset(coarse_gain_offset),
   .processing_clock(processing_clock), .agc_loop_gain_pick(agc_loop_gain_pick),
   .input_sample(input_sample), .input_sample_valid(input_sample_valid),
   .mixer_shift_code(mixer_shift_code), .carrier_offset_load(carrier_offset_load),
   .proc_sample_valid(proc_sample_valid), .agc_gain_setting(agc_gain_setting)
);
`default_nettype wire
